// [dcs_map.svh]
// register offsets, field positions, reset values and clock rates
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DCS_CTRL_OFS 4'h0
`define DCS_SKIP_OFS 4'h4
`define DCS_STAT_OFS 4'h8
`define DCS_KEPT_OFS 4'hc

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define DCS_REFSEL 1:0
`define DCS_CLKSEL 2
`define DCS_REFOUT 3
`define DCS_RATE10 4
`define DCS_CTRL_W 5
`define DCS_CTRL_RST 5'h00
`define DCS_SKIP_RST 16'h0001

// ----------------------------------------
// status fields
// ----------------------------------------
`define DCS_ST_LOCK 0
`define DCS_ST_ROLE 2:1
`define DCS_ST_CONFL 3
`define DCS_ST_FULL 4

// ----------------------------------------
// clock rates and bus answers
// ----------------------------------------
`define DCS_REF_KHZ 10000
`define DCS_TRIG_KHZ 20000000
`define DCS_SMP10_KHZ 10000000
`define DCS_SMP5_KHZ 5000000
`define DCS_DATA_KHZ 312500
`define DCS_RESP_OK 2'b00
`define DCS_RESP_ERR 2'b10

`endif

// [dcs_pkg.sv]
// shared types of the digitizer clock control block
package dcs_pkg;
  // reference source; the unused code falls back to internal
  typedef enum logic [1:0] {
    REF_INT = 2'h0,
    REF_FRONT = 2'h1,
    REF_BP = 2'h2
  } dcs_ref_t;
  // front connector role, gray along idle -> ref in -> clk in -> ref out
  typedef enum logic [1:0] {
    ROLE_IDLE = 2'h0,
    ROLE_REF_IN = 2'h1,
    ROLE_CLK_IN = 2'h3,
    ROLE_REF_OUT = 2'h2
  } dcs_role_t;
endpackage : dcs_pkg

// [dcs_fifo.sv]
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module dcs_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  // honest flags straight from the fill count
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_q];

  // storage
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
    end
  end

  // fill count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  fifo_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt_q == (AW+1)'(D)) && !pop |=> !in_ready)
    else $error("fifo took a word while full");
endmodule : dcs_fifo

// [dcs_clkgen.sv]
// derives trigger, sample and data clock enables from one base tick
`timescale 1ns/1ns
`include "dcs_map.svh"
module dcs_clkgen #(
  parameter int TRIG_PER_DATA = 64,
  parameter int CW = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // source tick and mode
  input wire logic base_tick,
  input wire logic rate10,
  input wire logic realign,
  // derived enables
  output logic trig_en,
  output logic smp_en,
  output logic data_en
);
  localparam int T10 = `DCS_TRIG_KHZ / `DCS_SMP10_KHZ;
  localparam int T5 = `DCS_TRIG_KHZ / `DCS_SMP5_KHZ;
  logic [CW-1:0] smp_cnt_q, data_cnt_q, smp_top;

  // trigger clock is the fastest and runs at the base tick
  assign trig_en = base_tick;
  assign smp_top = rate10 ? CW'(T10 - 1) : CW'(T5 - 1);
  assign smp_en = base_tick && (smp_cnt_q == smp_top);
  assign data_en = base_tick && (data_cnt_q == CW'(TRIG_PER_DATA - 1));

  // common restart keeps sample and data phases locked together
  always_ff @(posedge aclk) begin
    if (!aresetn || realign) begin
      smp_cnt_q <= '0;
      data_cnt_q <= '0;
    end else if (base_tick) begin
      smp_cnt_q <= smp_en ? '0 : smp_cnt_q + 1'b1;
      data_cnt_q <= data_en ? '0 : data_cnt_q + 1'b1;
    end
  end

  data_on_smp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    data_en |-> smp_en)
    else $error("data clock edge off a sample edge");
  trig_faster_a: assert property (@(posedge aclk) disable iff (!aresetn)
    smp_en |-> trig_en ##1 !smp_en)
    else $error("sample clock not slower than trigger clock");
endmodule : dcs_clkgen

// [dcs_top.sv]
// clock reference, clock source, reference output and sample skip control
`timescale 1ns/1ns
`include "dcs_map.svh"

// Function
// - built-in 10 MHz reference phase-locks all clocks; with an external clock the lock check uses no reference
// - external clock drives every derived clock
// - data clock slower, locked, samples in parallel
// - trigger clock fastest, also timestamp base
// - host side decoupled from sampling clock domain
// - selectable reference: internal, front, backplane
// - selectable source: internal generator or external
// - reference out drives selected reference on connector
// - connector role follows clock configuration only
// - keep one of N samples, no filtering
module dcs_top #(
  parameter int DW = 16,
  parameter int FIFO_D = 4,
  parameter int REF_RATIO = `DCS_TRIG_KHZ / `DCS_REF_KHZ,
  parameter int LCW = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // reference and generator ticks
  input wire logic int_ref_tick,
  input wire logic bp_ref_tick,
  input wire logic gen_tick,
  // shared front clock connector
  input wire logic sma_i,
  output logic sma_o,
  output logic sma_oe,
  // derived clock enables
  output logic trig_en,
  output logic smp_en,
  output logic data_en,
  // sample stream in
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [DW-1:0] s_data,
  // thinned stream out
  output logic m_valid,
  input wire logic m_ready,
  output logic [DW-1:0] m_data
);
  localparam int TPD = `DCS_TRIG_KHZ / `DCS_DATA_KHZ;

  // ----------------------------------------
  // registers and bus state
  // ----------------------------------------
  logic [`DCS_CTRL_W-1:0] ctrl_q;
  logic [15:0] skip_q, skip_cnt_q;
  logic [31:0] kept_q;
  logic aw_have_q, w_have_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic bvalid_q, rvalid_q;
  logic wr_do, wr_ctrl, wr_skip;

  // ----------------------------------------
  // clock configuration state
  // ----------------------------------------
  dcs_pkg::dcs_ref_t ref_sel;
  dcs_pkg::dcs_role_t role;
  logic clk_ext, rate10, refout_req, refout_ok, confl;
  logic sma_q, sma_rise, ref_tick, base_tick, realign;
  logic [LCW-1:0] lock_cnt_q;
  logic locked_q, sma_o_q, sma_oe_q;
  logic [`DCS_CTRL_W-1:0] ctrl_prev_q;

  // ----------------------------------------
  // skip path state
  // ----------------------------------------
  logic keep, in_fire, push_valid, fifo_ready;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  // one write at a time: address and data are held until both are in
  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign wr_do = aw_have_q && w_have_q;
  assign wr_ctrl = wr_do && (awaddr_q == `DCS_CTRL_OFS);
  assign wr_skip = wr_do && (awaddr_q == `DCS_SKIP_OFS);
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // response one cycle after both halves are in; status is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `DCS_RESP_OK;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_ctrl || wr_skip) ? `DCS_RESP_OK : `DCS_RESP_ERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // control register steers source selection and reference output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `DCS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= `DCS_CTRL_W'(merge(32'(ctrl_q), wdata_q, wstrb_q));
    end
  end

  // skip factor; zero is stored but acts as one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_q <= `DCS_SKIP_RST;
    end else if (wr_skip) begin
      skip_q <= 16'(merge(32'(skip_q), wdata_q, wstrb_q));
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // answer one cycle after the address; unmapped reads zero with error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `DCS_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `DCS_RESP_OK;
      case (araddr)
        `DCS_CTRL_OFS: rdata_q <= 32'(ctrl_q);
        `DCS_SKIP_OFS: rdata_q <= 32'(skip_q);
        `DCS_STAT_OFS: rdata_q <= {27'h0, !fifo_ready, confl, role, locked_q};
        `DCS_KEPT_OFS: rdata_q <= kept_q;
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= `DCS_RESP_ERR;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // reference and clock source selection
  // ----------------------------------------
  assign ref_sel = dcs_pkg::dcs_ref_t'(ctrl_q[`DCS_REFSEL]);
  assign clk_ext = ctrl_q[`DCS_CLKSEL];
  assign rate10 = ctrl_q[`DCS_RATE10];
  assign refout_req = ctrl_q[`DCS_REFOUT];
  // inputs are synchronous, so the previous level is enough for an edge
  assign sma_rise = sma_i && !sma_q;

  // selected reference tick, unused code falls back to internal
  always_comb begin
    case (ref_sel)
      dcs_pkg::REF_FRONT: ref_tick = sma_rise;
      dcs_pkg::REF_BP: ref_tick = bp_ref_tick;
      default: ref_tick = int_ref_tick;
    endcase
  end

  // external clock replaces the generator as the root of every clock
  assign base_tick = clk_ext ? sma_rise : gen_tick;

  // connector role falls out of the configuration, no setting of its own
  always_comb begin
    if (clk_ext) begin
      role = dcs_pkg::ROLE_CLK_IN;
    end else if (ref_sel == dcs_pkg::REF_FRONT) begin
      role = dcs_pkg::ROLE_REF_IN;
    end else if (refout_req) begin
      role = dcs_pkg::ROLE_REF_OUT;
    end else begin
      role = dcs_pkg::ROLE_IDLE;
    end
  end

  // driving out while the connector is an input would fight the source
  assign refout_ok = (role == dcs_pkg::ROLE_REF_OUT);
  assign confl = refout_req && !refout_ok;
  assign realign = (ctrl_q != ctrl_prev_q);

  // connector edge history and configuration history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sma_q <= 1'b0;
      ctrl_prev_q <= `DCS_CTRL_RST;
    end else begin
      sma_q <= sma_i;
      ctrl_prev_q <= ctrl_q;
    end
  end

  // reference output: the selected reference level on the connector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sma_o_q <= 1'b0;
      sma_oe_q <= 1'b0;
    end else begin
      sma_o_q <= refout_ok && ref_tick;
      sma_oe_q <= refout_ok;
    end
  end
  assign sma_o = sma_o_q;
  assign sma_oe = sma_oe_q;

  // ----------------------------------------
  // lock check against the reference
  // ----------------------------------------
  // counts trigger ticks per reference period with the internal generator; only a wrong
  // count or a control change drops the lock, since a stopped reference is indistinguishable
  // here; an external clock counts as locked from its first edge
  always_ff @(posedge aclk) begin
    if (!aresetn || realign) begin
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
    end else if (clk_ext) begin
      locked_q <= locked_q || base_tick;
    end else if (ref_tick) begin
      lock_cnt_q <= LCW'(base_tick);
      locked_q <= (lock_cnt_q == LCW'(REF_RATIO));
    end else if (base_tick) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // derived clock enables
  // ----------------------------------------
  dcs_clkgen #(
    .TRIG_PER_DATA(TPD),
    .CW(8)
  ) u_clkgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .base_tick(base_tick),
    .rate10(rate10),
    .realign(realign),
    .trig_en(trig_en),
    .smp_en(smp_en),
    .data_en(data_en)
  );

  // ----------------------------------------
  // sample skip
  // ----------------------------------------
  // keep the first of every group; no filter, dropped samples vanish
  assign keep = (skip_cnt_q == 16'h0000);
  assign in_fire = s_valid && s_ready;
  assign push_valid = s_valid && keep;
  // dropped samples are consumed without waiting on the fifo
  assign s_ready = keep ? fifo_ready : 1'b1;

  // group counter, restarted by any write to the factor
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_skip) begin
      skip_cnt_q <= 16'h0000;
    end else if (in_fire) begin
      if (skip_cnt_q + 16'h0001 >= skip_q) begin
        skip_cnt_q <= 16'h0000;
      end else begin
        skip_cnt_q <= skip_cnt_q + 16'h0001;
      end
    end
  end

  // count of kept samples for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kept_q <= 32'h0;
    end else if (in_fire && keep) begin
      kept_q <= kept_q + 32'h1;
    end
  end

  // buffer toward the host side, whose pace is its own
  dcs_fifo #(
    .W(DW),
    .D(FIFO_D)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(push_valid),
    .in_ready(fifo_ready),
    .in_data(s_data),
    .out_valid(m_valid),
    .out_ready(m_ready),
    .out_data(m_data)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  refout_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    refout_ok && ref_tick && !realign |=> sma_oe && sma_o)
    else $error("selected reference not driven out");
  no_fight_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_ext || ref_sel == dcs_pkg::REF_FRONT) ##1 $stable(ctrl_q) |-> !sma_oe)
    else $error("connector driven while it is an input");
  ext_root_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_ext && !sma_rise |-> !trig_en && !smp_en && !data_en)
    else $error("clock edge without an external clock edge");
  bp_ref_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_ext && ref_sel == dcs_pkg::REF_BP && bp_ref_tick && !realign |=> sma_oe == sma_o)
    else $error("backplane reference not selected");
  int_gen_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_ext |-> trig_en == gen_tick)
    else $error("internal generator not the clock root");
  lock_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_ext && $rose(locked_q) |-> $past(ref_tick))
    else $error("lock declared without a reference edge");
  skip_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    skip_q <= 16'h0001 && !$past(wr_skip) && in_fire |-> push_valid)
    else $error("factor one dropped a sample");
  skip_gap_a: assert property (@(posedge aclk) disable iff (!aresetn || wr_skip)
    in_fire && keep && skip_q == 16'h0004 ##1 (!wr_skip && skip_q == 16'h0004)[*1]
    |-> !keep)
    else $error("kept sample followed by another too soon");
  skip_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_skip |=> keep)
    else $error("skip counter not restarted");
endmodule : dcs_top

// [dcs_ext_src.sv]
// model of the external reference or direct clock source at the front connector
`timescale 1ns/1ns
module dcs_ext_src (
  // clock
  input wire logic aclk,
  // control from the bench
  input wire logic run,
  input wire logic [7:0] half,
  // source level toward the connector
  output logic lvl
);
  logic [7:0] cnt_q;

  // ----------------------------------------
  // fixed-rate square wave
  // ----------------------------------------
  // one rate whatever the sample mode; low while stopped, like a pulled-down line
  always_ff @(posedge aclk) begin
    if (!run) begin
      cnt_q <= 8'h00;
      lvl <= 1'h0;
    end else if (cnt_q >= half - 8'h01) begin
      cnt_q <= 8'h00;
      lvl <= !lvl;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : dcs_ext_src

// [dcs_top_tb.sv]
// self-checking bench of the digitizer clock control block
`timescale 1ns/1ns
`include "dcs_map.svh"
module dcs_top_tb;
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } dcs_row_t;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic int_ref_tick = 1'h0, bp_ref_tick = 1'h0, gen_tick = 1'h0, src_run = 1'h0;
  logic s_valid = 1'h0, m_ready = 1'h1;
  logic [15:0] s_data = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, sma_i, sma_o, sma_oe, src_lvl;
  logic trig_en, smp_en, data_en, s_ready, m_valid, pv;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd, k0;
  logic [15:0] m_data;
  logic [7:0] cyc = 8'h00;
  logic [15:0] got [$];
  dcs_row_t rows [22];
  int err_count = 0, n_tests = 0, n, nn;
  // ctrl, window, trigger, sample and data enable counts
  int ec [4][5] = '{'{0, 256, 128, 32, 2}, '{16, 256, 128, 64, 2},
                    '{4, 512, 64, 16, 1}, '{20, 512, 64, 32, 1}};
  int sk [4] = '{4, 3, 1, 0};

  // wire level: the device wins while it drives the connector
  assign sma_i = sma_oe ? sma_o : src_lvl;

  dcs_top #(.REF_RATIO(8)) dut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .int_ref_tick(int_ref_tick), .bp_ref_tick(bp_ref_tick), .gen_tick(gen_tick),
    .sma_i(sma_i), .sma_o(sma_o), .sma_oe(sma_oe), .trig_en(trig_en),
    .smp_en(smp_en), .data_en(data_en), .s_valid(s_valid), .s_ready(s_ready),
    .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data));

  dcs_ext_src src (.aclk(aclk), .run(src_run), .half(8'h04), .lvl(src_lvl));

  // ----------------------------------------
  // clock, ticks and output monitor
  // ----------------------------------------
  always #5 aclk = ~aclk;

  // generator ticks every 2 cycles, references every 16: eight ticks per reference
  always @(posedge aclk) begin
    cyc <= cyc + 8'h01;
    gen_tick <= cyc[0];
    int_ref_tick <= (cyc[3:0] == 4'h0);
    bp_ref_tick <= (cyc[3:0] == 4'h5);
  end

  // collect every word taken from the thinned stream
  always @(posedge aclk) begin
    if (m_valid === 1'h1 && m_ready === 1'h1) got.push_back(m_data);
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask : axw

  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : axr

  // valid stays up afterwards, so back-to-back sends never re-raise it
  task automatic send(input logic [15:0] d);
    s_valid <= 1'h1;
    s_data <= d;
    do @(posedge aclk); while (s_ready !== 1'h1);
  endtask : send

  task automatic count_en(input int w, input int t, input int s, input int d);
    int ct = 0, cs = 0, cd = 0;
    repeat (w) begin
      @(posedge aclk);
      ct += (trig_en === 1'h1);
      cs += (smp_en === 1'h1);
      cd += (data_en === 1'h1);
    end
    check(ct, t);
    check(cs, s);
    check(cd, d);
  endtask : count_en

  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  // cut a hang short well past the expected few thousand cycles
  initial begin
    #400000;
    err_count++;
    final_report();
  end

  initial begin
    // write rows: wr, addr, data, -, resp; read rows: wr, addr, expect, mask, resp
    rows = '{'{1'h0, 4'h0, 32'h0, '1, 2'h0}, '{1'h0, 4'h4, 32'h1, '1, 2'h0},
      '{1'h0, 4'h8, 32'h0, 32'he, 2'h0}, '{1'h0, 4'hc, 32'h0, '1, 2'h0},
      '{1'h1, 4'h0, 32'h1f, 32'h0, 2'h0}, '{1'h0, 4'h0, 32'h1f, '1, 2'h0},
      '{1'h0, 4'h8, 32'he, 32'he, 2'h0}, '{1'h1, 4'h0, 32'h1, 32'h0, 2'h0},
      '{1'h0, 4'h8, 32'h2, 32'he, 2'h0}, '{1'h1, 4'h0, 32'h8, 32'h0, 2'h0},
      '{1'h0, 4'h8, 32'h4, 32'he, 2'h0}, '{1'h1, 4'h0, 32'h9, 32'h0, 2'h0},
      '{1'h0, 4'h8, 32'ha, 32'he, 2'h0}, '{1'h1, 4'h0, 32'h4, 32'h0, 2'h0},
      '{1'h0, 4'h8, 32'h6, 32'he, 2'h0}, '{1'h1, 4'h8, 32'hff, 32'h0, 2'h2},
      '{1'h1, 4'hc, 32'hff, 32'h0, 2'h2}, '{1'h1, 4'h6, 32'hff, 32'h0, 2'h2},
      '{1'h0, 4'h6, 32'h0, '1, 2'h2}, '{1'h0, 4'h0, 32'h4, '1, 2'h0},
      '{1'h1, 4'h4, 32'h12345, 32'h0, 2'h0}, '{1'h0, 4'h4, 32'h2345, '1, 2'h0}};
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    src_run <= 1'h1;
    @(posedge aclk);
    check(sma_oe, 32'h0);
    check(s_ready, 32'h1);
    check(m_valid, 32'h0);
    // register and connector-role table
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axw(rows[i].a, rows[i].d);
      end else begin
        axr(rows[i].a);
        check(rd & rows[i].m, rows[i].d);
      end
      check(resp, rows[i].r);
    end
    // derived enables and lock for internal and external sources, both rates
    for (int i = 0; i < 4; i++) begin
      axw(`DCS_CTRL_OFS, ec[i][0]);
      repeat (40) @(posedge aclk);
      count_en(ec[i][1], ec[i][2], ec[i][3], ec[i][4]);
      axr(`DCS_STAT_OFS);
      check(rd & 32'h1, 32'h1);
    end
    // reference out from internal then backplane reference
    for (int i = 0; i < 2; i++) begin
      axw(`DCS_CTRL_OFS, i ? 32'ha : 32'h8);
      repeat (4) @(posedge aclk);
      check(sma_oe, 32'h1);
      pv = i ? bp_ref_tick : int_ref_tick;
      repeat (40) begin
        @(posedge aclk);
        check(sma_o, pv);
        pv = i ? bp_ref_tick : int_ref_tick;
      end
    end
    axw(`DCS_CTRL_OFS, 32'h9);
    repeat (4) @(posedge aclk);
    check(sma_oe, 32'h0);
    // skip factors; the writes of 3 and 1 restart mid-group, zero acts as one
    for (int i = 0; i < 4; i++) begin
      axw(`DCS_SKIP_OFS, sk[i]);
      axr(`DCS_KEPT_OFS);
      k0 = rd;
      got.delete();
      for (int j = 0; j < 10; j++) send(16'(i * 16 + j));
      s_valid <= 1'h0;
      repeat (8) @(posedge aclk);
      nn = (sk[i] == 0) ? 1 : sk[i];
      n = 0;
      for (int j = 0; j < 10; j++) begin
        if (j % nn == 0) begin
          check(got[n], i * 16 + j);
          n++;
        end
      end
      check(got.size(), n);
      axr(`DCS_KEPT_OFS);
      check(rd - k0, n);
    end
    // fill the fifo with the far side stalled, then drain it
    axw(`DCS_SKIP_OFS, 32'h1);
    got.delete();
    m_ready <= 1'h0;
    for (int j = 0; j < 4; j++) send(16'(j));
    s_data <= 16'h4;
    repeat (3) @(posedge aclk);
    check(s_ready, 32'h0);
    check(m_valid, 32'h1);
    axr(`DCS_STAT_OFS);
    check(rd & 32'h10, 32'h10);
    m_ready <= 1'h1;
    do @(posedge aclk); while (s_ready !== 1'h1);
    s_valid <= 1'h0;
    repeat (10) @(posedge aclk);
    check(got.size(), 32'h5);
    for (int j = 0; j < 5; j++) check(got[j], j);
    // second reset in mid-run brings control back to defaults
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axr(`DCS_CTRL_OFS);
    check(rd, 32'h0);
    final_report();
  end
endmodule : dcs_top_tb
